/* core/image_transfer_pkg.sv */
// Constants, types and register map of the image transfer and palette block
package image_transfer_pkg;

	// Register byte addresses on the host bus
	localparam logic [23:0] PAL_BASE_ADDR    = 24'h7fff00;
	localparam logic [23:0] PAL_LAST_ADDR    = 24'h7fff7e;
	localparam logic [23:0] ROM_BANK_ADDR    = 24'h7fffc0;
	localparam logic [23:0] START_X_ADDR     = 24'h7fffc2;
	localparam logic [23:0] START_Y_ADDR     = 24'h7fffc4;
	localparam logic [23:0] ROM_UPPER_ADDR   = 24'h7fffc6;
	localparam logic [23:0] ROM_LOWER_ADDR   = 24'h7fffc8;
	localparam logic [23:0] WIDTH_ADDR       = 24'h7fffca;
	localparam logic [23:0] HEIGHT_ADDR      = 24'h7fffcc;
	localparam logic [23:0] CONTROL_ADDR     = 24'h7fffce;

	// Palette geometry and field widths
	localparam int PAL_ENTRIES   = 64;
	localparam int PAL_IDX_W     = 6;
	localparam int COLOR_W       = 12;
	localparam int NIBBLE_W      = 4;

	// Field widths and positions
	localparam int BANK_LSB      = 3;
	localparam int BANK_W        = 3;
	localparam int START_X_W     = 11;
	localparam int START_Y_W     = 10;
	localparam int ROM_UPPER_W   = 9;
	localparam int ROM_ADDR_W    = 25;
	localparam int IMG_WIDTH_W   = 12;
	localparam int IMG_HEIGHT_W  = 11;
	localparam int GO_BIT        = 8;

	// Reset values
	localparam logic [7:0]  BANK_RESET  = 8'h00;
	localparam logic [15:0] PARAM_RESET = 16'h0000;

	// Timing
	localparam int CLK_PERIOD_NS     = 100;
	localparam int DONE_PULSE_NS     = 1000;
	localparam int DONE_PULSE_CYCLES = (DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROM_READ_NS       = 200;
	localparam int ROM_READ_CYCLES   = (ROM_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH        = 32;

	typedef enum logic [1:0] {
		XFER_IDLE   = 2'b00,
		XFER_GRANT  = 2'b01,
		XFER_READ   = 2'b11,
		XFER_FINISH = 2'b10
	} xfer_state_e;

	typedef struct packed {
		logic [23:1] addr;
		logic [15:0] data;
		logic        hi;
		logic        lo;
	} host_write_s;

	typedef struct packed {
		logic [START_X_W-1:0] x;
		logic [START_Y_W-1:0] y;
		logic [15:0]          data;
	} pixel_s;

endpackage

/* core/stream_fifo.sv */
// Valid/ready FIFO between image ROM reads and frame buffer writes
`timescale 1ns/1ns
module stream_fifo #(
	parameter int WIDTH = 37,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic [AW:0]      nxt_wr_ptr;
	logic [AW:0]      nxt_rd_ptr;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign empty       = (wr_ptr_ff == rd_ptr_ff);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;

	always_comb begin
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
		end
	end
endmodule

/* core/done_pulse_gen.sv */
// One-shot active-low completion pulse of fixed length
`timescale 1ns/1ns
module done_pulse_gen (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Trigger and pulse
	input  wire logic i_fire,
	output logic      o_pulse_n
);
	localparam int CW = $clog2(image_transfer_pkg::DONE_PULSE_CYCLES + 1);
	localparam logic [CW-1:0] LEN = CW'(image_transfer_pkg::DONE_PULSE_CYCLES);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          pulse_n_ff;
	logic          nxt_pulse_n;

	assign o_pulse_n = pulse_n_ff;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (i_fire) begin
			nxt_cnt = LEN;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		nxt_pulse_n = (nxt_cnt == '0);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_ff     <= '0;
			pulse_n_ff <= 1'b1;
		end else begin
			cnt_ff     <= nxt_cnt;
			pulse_n_ff <= nxt_pulse_n;
		end
	end
endmodule

/* core/image_transfer_palette_regs.sv */
// Host register bank: palette, ROM bank, image transfer parameters and self-refresh
`timescale 1ns/1ns
// Notes on behaviour
// - Sleep request one puts SDRAM in self-refresh
// - Panel shows black while in self-refresh
// - Sleep request zero restores SDRAM and picture
// - No frame buffer access during self-refresh
// - Sixty-four palette entries of twelve bits
// - Palette word write: high byte GB, low R
// - Entry n at base plus 2n, even GB
// - Bank bits five to three drive ROM pins
// - Bank register word write uses high byte
// - Eleven-bit horizontal start coordinate held
// - Ten-bit vertical start coordinate held
// - Out-of-range values stored without clamping
// - Parameter registers take byte or word writes
// - Twenty-five-bit ROM start address held
// - Twelve-bit transfer width held
// - Eleven-bit transfer height held
// - Go bit starts transfer, then clears
// - One microsecond low pulse on completion
// - Transfer requests and holds the host bus
module image_transfer_palette_regs (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Host write bus
	input  wire logic        i_cs_n,
	input  wire logic        i_wr_n,
	input  wire logic        i_byte_hi_n,
	input  wire logic        i_byte_lo_n,
	input  wire logic [23:1] i_addr,
	input  wire logic [15:0] i_data,
	// Host bus takeover and image ROM
	input  wire logic        i_bus_grant_n,
	output logic             o_bus_request_n,
	output logic [24:0]      o_rom_addr,
	output logic             o_rom_rd_n,
	input  wire logic [15:0] i_rom_data,
	output logic             o_done_pulse_out_n,
	// ROM bank outputs
	output logic             o_rom_bank_bit_top,
	output logic             o_rom_bank_bit_mid,
	output logic             o_rom_bank_bit_low,
	// Self-refresh control
	input  wire logic        i_memory_sleep_request,
	output logic             o_sdram_self_refresh,
	output logic             o_display_black,
	// Palette lookup for the panel
	input  wire logic [5:0]  i_pal_index,
	output logic [11:0]      o_panel_color,
	// Frame buffer write port
	output logic             o_fb_wr,
	output logic [10:0]      o_fb_x,
	output logic [9:0]       o_fb_y,
	output logic [15:0]      o_fb_data,
	input  wire logic        i_fb_ready
);
	localparam int RCW = $clog2(image_transfer_pkg::ROM_READ_CYCLES + 1);
	localparam logic [RCW-1:0] RD_LAST = RCW'(image_transfer_pkg::ROM_READ_CYCLES - 1);

	// Match of a word address against a register byte address
	function automatic logic hit(input logic [23:1] a, input logic [23:0] reg_addr);
		hit = (a == reg_addr[23:1]);
	endfunction

	// Byte-lane merge into a word register
	function automatic logic [15:0] merge(input logic [15:0] old, input image_transfer_pkg::host_write_s w);
		merge = {w.hi ? w.data[15:8] : old[15:8], w.lo ? w.data[7:0] : old[7:0]};
	endfunction

	// Pin synchronisers: strobe and grant
	logic [2:0] wr_sync_ff;
	logic [2:0] gnt_sync_ff;
	logic       wr_level_ff;
	logic       gnt_level_ff;
	logic [2:0] nxt_wr_sync;
	logic [2:0] nxt_gnt_sync;
	logic       nxt_wr_level;
	logic       nxt_gnt_level;
	logic       wr_take;
	image_transfer_pkg::host_write_s hw;

	always_comb begin
		nxt_wr_sync   = {wr_sync_ff[1:0], i_wr_n};
		nxt_gnt_sync  = {gnt_sync_ff[1:0], i_bus_grant_n};
		nxt_wr_level  = (wr_sync_ff[1] == wr_sync_ff[2]) ? wr_sync_ff[2] : wr_level_ff;
		nxt_gnt_level = (gnt_sync_ff[1] == gnt_sync_ff[2]) ? gnt_sync_ff[2] : gnt_level_ff;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_sync_ff   <= 3'h7;
			gnt_sync_ff  <= 3'h7;
			wr_level_ff  <= 1'b1;
			gnt_level_ff <= 1'b1;
		end else begin
			wr_sync_ff   <= nxt_wr_sync;
			gnt_sync_ff  <= nxt_gnt_sync;
			wr_level_ff  <= nxt_wr_level;
			gnt_level_ff <= nxt_gnt_level;
		end
	end

	// Address, data and lanes are held by the host for the whole strobe
	assign wr_take = wr_level_ff && !nxt_wr_level && !i_cs_n;
	assign hw      = '{addr: i_addr, data: i_data, hi: !i_byte_hi_n, lo: !i_byte_lo_n};

	// Parameter registers
	logic [7:0]  bank_ff;
	logic [15:0] start_x_ff;
	logic [15:0] start_y_ff;
	logic [15:0] rom_up_ff;
	logic [15:0] rom_lo_ff;
	logic [15:0] width_ff;
	logic [15:0] height_ff;
	logic        go_ff;
	logic [7:0]  nxt_bank;
	logic [15:0] nxt_start_x;
	logic [15:0] nxt_start_y;
	logic [15:0] nxt_rom_up;
	logic [15:0] nxt_rom_lo;
	logic [15:0] nxt_width;
	logic [15:0] nxt_height;
	logic        nxt_go;
	logic        xfer_start;

	always_comb begin
		nxt_bank    = bank_ff;
		nxt_start_x = start_x_ff;
		nxt_start_y = start_y_ff;
		nxt_rom_up  = rom_up_ff;
		nxt_rom_lo  = rom_lo_ff;
		nxt_width   = width_ff;
		nxt_height  = height_ff;
		nxt_go      = xfer_start ? 1'b0 : go_ff;
		if (wr_take) begin
			if (hit(hw.addr, image_transfer_pkg::ROM_BANK_ADDR) && hw.hi) begin
				nxt_bank = hw.data[15:8];
			end
			if (hit(hw.addr, image_transfer_pkg::START_X_ADDR)) begin
				nxt_start_x = merge(start_x_ff, hw) & 16'h07ff;
			end
			if (hit(hw.addr, image_transfer_pkg::START_Y_ADDR)) begin
				nxt_start_y = merge(start_y_ff, hw) & 16'h03ff;
			end
			if (hit(hw.addr, image_transfer_pkg::ROM_UPPER_ADDR)) begin
				nxt_rom_up = merge(rom_up_ff, hw) & 16'h01ff;
			end
			if (hit(hw.addr, image_transfer_pkg::ROM_LOWER_ADDR)) begin
				nxt_rom_lo = merge(rom_lo_ff, hw);
			end
			if (hit(hw.addr, image_transfer_pkg::WIDTH_ADDR)) begin
				nxt_width = merge(width_ff, hw) & 16'h0fff;
			end
			if (hit(hw.addr, image_transfer_pkg::HEIGHT_ADDR)) begin
				nxt_height = merge(height_ff, hw) & 16'h07ff;
			end
			// A fresh go beats the clear of the start cycle
			if (hit(hw.addr, image_transfer_pkg::CONTROL_ADDR) && hw.hi && hw.data[image_transfer_pkg::GO_BIT]) begin
				nxt_go = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			bank_ff    <= image_transfer_pkg::BANK_RESET;
			start_x_ff <= image_transfer_pkg::PARAM_RESET;
			start_y_ff <= image_transfer_pkg::PARAM_RESET;
			rom_up_ff  <= image_transfer_pkg::PARAM_RESET;
			rom_lo_ff  <= image_transfer_pkg::PARAM_RESET;
			width_ff   <= image_transfer_pkg::PARAM_RESET;
			height_ff  <= image_transfer_pkg::PARAM_RESET;
			go_ff      <= 1'b0;
		end else begin
			bank_ff    <= nxt_bank;
			start_x_ff <= nxt_start_x;
			start_y_ff <= nxt_start_y;
			rom_up_ff  <= nxt_rom_up;
			rom_lo_ff  <= nxt_rom_lo;
			width_ff   <= nxt_width;
			height_ff  <= nxt_height;
			go_ff      <= nxt_go;
		end
	end

	assign o_rom_bank_bit_top = bank_ff[image_transfer_pkg::BANK_LSB + 2];
	assign o_rom_bank_bit_mid = bank_ff[image_transfer_pkg::BANK_LSB + 1];
	assign o_rom_bank_bit_low = bank_ff[image_transfer_pkg::BANK_LSB];

	// Palette memory, write-only from the host
	logic [11:0] palette [image_transfer_pkg::PAL_ENTRIES];
	logic        pal_hit;
	logic [5:0]  pal_idx;

	assign pal_hit = (hw.addr[23:7] == image_transfer_pkg::PAL_BASE_ADDR[23:7]);
	assign pal_idx = hw.addr[6:1];

	always_ff @(posedge i_clk) begin
		if (wr_take && pal_hit) begin
			if (hw.hi) begin
				palette[pal_idx][7:0] <= hw.data[15:8];
			end
			if (hw.lo) begin
				palette[pal_idx][11:8] <= hw.data[3:0];
			end
		end
	end

	// Self-refresh and panel colour
	logic        sleep_ff;
	logic [11:0] color_ff;
	logic        nxt_sleep;
	logic [11:0] nxt_color;

	always_comb begin
		nxt_sleep = i_memory_sleep_request;
		nxt_color = i_memory_sleep_request ? 12'h000 : palette[i_pal_index];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sleep_ff <= 1'b0;
			color_ff <= 12'h000;
		end else begin
			sleep_ff <= nxt_sleep;
			color_ff <= nxt_color;
		end
	end

	assign o_sdram_self_refresh = sleep_ff;
	assign o_display_black      = sleep_ff;
	assign o_panel_color        = color_ff;

	// Transfer engine
	image_transfer_pkg::xfer_state_e state_ff, nxt_state;
	logic [24:0]    rom_ptr_ff;
	logic [11:0]    col_ff;
	logic [10:0]    line_ff;
	logic           reading_ff;
	logic [RCW-1:0] rd_cnt_ff;
	logic           req_n_ff;
	logic [24:0]    nxt_rom_ptr;
	logic [11:0]    nxt_col;
	logic [10:0]    nxt_line;
	logic           nxt_reading;
	logic [RCW-1:0] nxt_rd_cnt;
	logic           nxt_req_n;
	logic           done_fire;
	logic           push_valid;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic           fb_pend_ff;
	logic           nxt_fb_pend;
	image_transfer_pkg::pixel_s push_px, pop_px;

	assign push_valid = reading_ff && (rd_cnt_ff == '0);
	assign push_px    = '{x: start_x_ff[10:0] + col_ff[10:0], y: start_y_ff[9:0] + line_ff[9:0], data: i_rom_data};
	assign xfer_start = (state_ff == image_transfer_pkg::XFER_IDLE) && go_ff;

	always_comb begin
		nxt_state   = state_ff;
		nxt_rom_ptr = rom_ptr_ff;
		nxt_col     = col_ff;
		nxt_line    = line_ff;
		nxt_reading = reading_ff;
		nxt_rd_cnt  = rd_cnt_ff;
		nxt_req_n   = req_n_ff;
		done_fire   = 1'b0;
		case (state_ff)
			image_transfer_pkg::XFER_IDLE: begin
				if (go_ff) begin
					nxt_rom_ptr = {rom_up_ff[8:0], rom_lo_ff};
					nxt_col     = '0;
					nxt_line    = '0;
					nxt_req_n   = 1'b0;
					nxt_state   = image_transfer_pkg::XFER_GRANT;
				end
			end
			image_transfer_pkg::XFER_GRANT: begin
				if (!gnt_level_ff) begin
					nxt_state = image_transfer_pkg::XFER_READ;
				end
			end
			image_transfer_pkg::XFER_READ: begin
				if (!reading_ff) begin
					// Only start a read when its word has room
					if (fifo_in_ready) begin
						nxt_reading = 1'b1;
						nxt_rd_cnt  = RD_LAST;
					end
				end else if (rd_cnt_ff != '0) begin
					nxt_rd_cnt = rd_cnt_ff - 1'b1;
				end else begin
					nxt_reading = 1'b0;
					nxt_rom_ptr = rom_ptr_ff + 25'h0000001;
					// No clamp: a zero size wraps to the full count
					if (col_ff == width_ff[11:0] - 12'h001) begin
						nxt_col  = '0;
						nxt_line = line_ff + 11'h001;
						if (line_ff == height_ff[10:0] - 11'h001) begin
							nxt_state = image_transfer_pkg::XFER_FINISH;
						end
					end else begin
						nxt_col = col_ff + 12'h001;
					end
				end
			end
			image_transfer_pkg::XFER_FINISH: begin
				// Bus is held until the last pixel reaches the frame buffer
				if (!fifo_out_valid && !fb_pend_ff) begin
					nxt_req_n = 1'b1;
					done_fire = 1'b1;
					nxt_state = image_transfer_pkg::XFER_IDLE;
				end
			end
			default: begin
				nxt_state = image_transfer_pkg::XFER_IDLE;
				nxt_req_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_ff   <= image_transfer_pkg::XFER_IDLE;
			rom_ptr_ff <= '0;
			col_ff     <= '0;
			line_ff    <= '0;
			reading_ff <= 1'b0;
			rd_cnt_ff  <= '0;
			req_n_ff   <= 1'b1;
		end else begin
			state_ff   <= nxt_state;
			rom_ptr_ff <= nxt_rom_ptr;
			col_ff     <= nxt_col;
			line_ff    <= nxt_line;
			reading_ff <= nxt_reading;
			rd_cnt_ff  <= nxt_rd_cnt;
			req_n_ff   <= nxt_req_n;
		end
	end

	assign o_bus_request_n = req_n_ff;
	assign o_rom_addr      = rom_ptr_ff;
	assign o_rom_rd_n      = !reading_ff;

	// Frame buffer write stage
	logic        fb_wr_ff;
	logic        nxt_fb_wr;
	logic        pop;
	image_transfer_pkg::pixel_s fb_px_ff, nxt_fb_px;

	// Drain stalls in self-refresh so the FIFO backs up the ROM reads
	assign pop = fifo_out_valid && !sleep_ff && (!fb_pend_ff || (fb_wr_ff && i_fb_ready));

	always_comb begin
		nxt_fb_px   = pop ? pop_px : fb_px_ff;
		nxt_fb_pend = pop || (fb_pend_ff && !(fb_wr_ff && i_fb_ready));
		nxt_fb_wr   = nxt_fb_pend && !i_memory_sleep_request;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			fb_px_ff   <= '0;
			fb_pend_ff <= 1'b0;
			fb_wr_ff   <= 1'b0;
		end else begin
			fb_px_ff   <= nxt_fb_px;
			fb_pend_ff <= nxt_fb_pend;
			fb_wr_ff   <= nxt_fb_wr;
		end
	end

	assign o_fb_wr   = fb_wr_ff;
	assign o_fb_x    = fb_px_ff.x;
	assign o_fb_y    = fb_px_ff.y;
	assign o_fb_data = fb_px_ff.data;

	stream_fifo #(
		.WIDTH($bits(image_transfer_pkg::pixel_s)),
		.DEPTH(image_transfer_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (push_valid),
		.i_in_data   (push_px),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (pop_px),
		.i_out_ready (pop)
	);

	done_pulse_gen u_done (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_fire    (done_fire),
		.o_pulse_n (o_done_pulse_out_n)
	);
endmodule

/* verif/image_xfer_chk.sv */
// Concurrent checks on the image transfer and palette register bank
`timescale 1ns/1ns
module image_xfer_chk (
	// Clock, reset and inputs
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_wr_n,
	input wire logic        i_memory_sleep_request,
	input wire logic        i_fb_ready,
	// Outputs
	input wire logic        o_bus_request_n,
	input wire logic [24:0] o_rom_addr,
	input wire logic        o_rom_rd_n,
	input wire logic        o_done_pulse_out_n,
	input wire logic        o_rom_bank_bit_top,
	input wire logic        o_rom_bank_bit_mid,
	input wire logic        o_rom_bank_bit_low,
	input wire logic        o_sdram_self_refresh,
	input wire logic        o_display_black,
	input wire logic [11:0] o_panel_color,
	input wire logic        o_fb_wr,
	input wire logic [10:0] o_fb_x,
	input wire logic [9:0]  o_fb_y,
	input wire logic [15:0] o_fb_data
);
	logic [4:0] low_cnt_ff;
	logic [4:0] nxt_low_cnt;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Counts low cycles so a pulse longer than the repetition limit can be measured
	always_comb begin
		nxt_low_cnt = (!i_rst_n || o_done_pulse_out_n) ? 5'h00 : low_cnt_ff + 5'h01;
	end
	always_ff @(posedge i_clk) begin
		low_cnt_ff <= nxt_low_cnt;
	end
	sequence rd_held;
		!o_rom_rd_n ##1 (!o_rom_rd_n && $stable(o_rom_addr)) ##1 o_rom_rd_n;
	endsequence
	sequence pulse_starts;
		$fell(o_done_pulse_out_n);
	endsequence
	a_sleep_enter: assert property (i_memory_sleep_request |=> o_sdram_self_refresh && o_display_black)
		else $error("self-refresh not entered");
	a_sleep_exit: assert property (!i_memory_sleep_request |=> !o_sdram_self_refresh && !o_display_black)
		else $error("self-refresh not left");
	a_black_panel: assert property (o_display_black |-> o_panel_color == 12'h000)
		else $error("panel not black");
	a_no_fb_asleep: assert property (o_sdram_self_refresh |-> !o_fb_wr)
		else $error("frame buffer written in self-refresh");
	a_bank_quiet: assert property (i_wr_n [*8] |=> $stable({o_rom_bank_bit_top, o_rom_bank_bit_mid, o_rom_bank_bit_low}))
		else $error("bank pins moved without a write");
	a_rom_read: assert property ($fell(o_rom_rd_n) |-> rd_held)
		else $error("rom read shape wrong");
	a_read_owns_bus: assert property (!o_rom_rd_n |-> !o_bus_request_n)
		else $error("rom read without bus");
	a_done_follows: assert property ($rose(o_bus_request_n) |-> pulse_starts)
		else $error("no done pulse after bus release");
	a_done_width: assert property ($rose(o_done_pulse_out_n) |-> low_cnt_ff == 5'(image_transfer_pkg::DONE_PULSE_CYCLES))
		else $error("done pulse width wrong");
	a_done_bus_free: assert property (!o_done_pulse_out_n |-> o_bus_request_n)
		else $error("done pulse while bus held");
	a_pixel_hold: assert property (o_fb_wr && !i_fb_ready && !i_memory_sleep_request
		|=> o_fb_wr && $stable({o_fb_x, o_fb_y, o_fb_data}))
		else $error("pixel write dropped");
endmodule
bind image_transfer_palette_regs image_xfer_chk image_xfer_chk_inst (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_n(i_wr_n), .i_memory_sleep_request(i_memory_sleep_request),
	.i_fb_ready(i_fb_ready), .o_bus_request_n(o_bus_request_n), .o_rom_addr(o_rom_addr), .o_rom_rd_n(o_rom_rd_n),
	.o_done_pulse_out_n(o_done_pulse_out_n), .o_rom_bank_bit_top(o_rom_bank_bit_top),
	.o_rom_bank_bit_mid(o_rom_bank_bit_mid), .o_rom_bank_bit_low(o_rom_bank_bit_low),
	.o_sdram_self_refresh(o_sdram_self_refresh), .o_display_black(o_display_black), .o_panel_color(o_panel_color),
	.o_fb_wr(o_fb_wr), .o_fb_x(o_fb_x), .o_fb_y(o_fb_y), .o_fb_data(o_fb_data));

/* verif/host_rom_model.sv */
// Host side partner: grants the bus on request and answers image ROM reads
`timescale 1ns/1ns
module host_rom_model (
	// Clock and pace
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	// Bus takeover and image ROM
	input  wire logic        i_bus_request_n,
	output logic             o_bus_grant_n,
	input  wire logic [24:0] i_rom_addr,
	input  wire logic        i_rom_rd_n,
	output logic [15:0]      o_rom_data
);
	int wait_cnt;
	initial begin
		o_bus_grant_n = 1'b1;
		o_rom_data = 16'h0000;
		wait_cnt = 0;
	end
	// Grant after a delay, held until the request drops
	always @(posedge i_clk) begin
		wait_cnt <= i_bus_request_n ? 0 : wait_cnt + 1;
		o_bus_grant_n <= i_bus_request_n || (wait_cnt < (i_slow ? 6 : 0));
		// Outside a read the data lines toggle so stale values never look valid
		o_rom_data <= !i_rom_rd_n ? (i_rom_addr[15:0] ^ 16'ha5c3) : ~o_rom_data;
	end
endmodule

/* verif/tb.sv */
// Self-checking testbench of the image transfer and palette register bank
`timescale 1ns/1ns
module tb;
	logic i_clk, i_rst_n, cs_n, wr_n, hi_n, lo_n, sleep, fb_ready, slow;
	logic [23:1] addr;
	logic [15:0] data;
	logic [5:0] pal_idx;
	wire grant_n, req_n, rd_n, done_n, b_top, b_mid, b_low, sref, black, fb_wr;
	wire [24:0] rom_addr;
	wire [15:0] rom_data, fb_data;
	wire [11:0] color;
	wire [10:0] fb_x;
	wire [9:0] fb_y;
	int failures, checks, cycles;
	logic [31:0] seed;
	logic [11:0] pal_m [64];
	logic [36:0] exp_q [$];
	int x0, y0, rom0;

	image_transfer_palette_regs image_transfer_palette_regs_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_cs_n(cs_n), .i_wr_n(wr_n), .i_byte_hi_n(hi_n), .i_byte_lo_n(lo_n), .i_addr(addr), .i_data(data),
		.i_bus_grant_n(grant_n), .o_bus_request_n(req_n), .o_rom_addr(rom_addr), .o_rom_rd_n(rd_n),
		.i_rom_data(rom_data), .o_done_pulse_out_n(done_n), .o_rom_bank_bit_top(b_top),
		.o_rom_bank_bit_mid(b_mid), .o_rom_bank_bit_low(b_low), .i_memory_sleep_request(sleep),
		.o_sdram_self_refresh(sref), .o_display_black(black), .i_pal_index(pal_idx), .o_panel_color(color),
		.o_fb_wr(fb_wr), .o_fb_x(fb_x), .o_fb_y(fb_y), .o_fb_data(fb_data), .i_fb_ready(fb_ready));
	host_rom_model host_rom_model_inst (.i_clk(i_clk), .i_slow(slow), .i_bus_request_n(req_n),
		.o_bus_grant_n(grant_n), .i_rom_addr(rom_addr), .i_rom_rd_n(rd_n), .o_rom_data(rom_data));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Strobe held well past the synchroniser delay, then idle before the next
	task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic h, input logic l);
		@(posedge i_clk);
		cs_n <= 1'b0;
		addr <= a[23:1];
		data <= d;
		hi_n <= h;
		lo_n <= l;
		wr_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		cs_n <= 1'b1;
		hi_n <= 1'b1;
		lo_n <= 1'b1;
	endtask
	task automatic xfer(input logic s, input int w, input int h, input int stall);
		int lowc;
		lowc = 0;
		slow <= s;
		wr(image_transfer_pkg::WIDTH_ADDR, 16'hf000 | 16'(w), 1'b0, 1'b0);
		wr(image_transfer_pkg::HEIGHT_ADDR, 16'hf800 | 16'(h), 1'b0, 1'b0);
		for (int l = 0; l < h; l++)
			for (int c = 0; c < w; c++)
				exp_q.push_back({11'(x0 + c), 10'(y0 + l), 16'(rom0 + l * w + c) ^ 16'ha5c3});
		wr(image_transfer_pkg::CONTROL_ADDR, 16'h01ff, 1'b0, 1'b1);
		for (int i = 0; i < 3000 && !(lowc > 0 && done_n); i++) begin
			@(posedge i_clk);
			seed = xs(seed);
			fb_ready <= (i >= stall) && seed[0];
			// Short sleeps while pixels are in flight; released once the done pulse starts
			sleep <= (i >= stall) && (lowc == 0) && (seed[3:1] == 3'h0);
			if (!done_n)
				lowc++;
		end
		chk("done pulse cycles", 37'(image_transfer_pkg::DONE_PULSE_CYCLES), 37'(lowc));
		chk("pixels missing", 37'h0, 37'(exp_q.size()));
	endtask

	always @(posedge i_clk) begin
		if (i_rst_n && fb_wr && fb_ready) begin
			if (exp_q.size() == 0)
				chk("extra pixel", 37'h0, {fb_x, fb_y, fb_data});
			else
				chk("pixel", exp_q.pop_front(), {fb_x, fb_y, fb_data});
		end
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial begin
		{cs_n, wr_n, hi_n, lo_n} = 4'hf;
		{i_rst_n, sleep, fb_ready, slow} = 4'h0;
		addr = 23'h000000;
		data = 16'h0000;
		pal_idx = 6'h00;
		seed = 32'h000078f1;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		chk("reset outputs", 37'h1c, 37'({b_top, b_mid, b_low, req_n, rd_n, done_n, fb_wr, sref}));
		for (int n = 0; n < 64; n++) begin
			seed = xs(seed);
			wr(image_transfer_pkg::PAL_BASE_ADDR + 24'(2 * n), seed[15:0], 1'b0, 1'b0);
			pal_m[n] = {seed[3:0], seed[15:8]};
		end
		wr(image_transfer_pkg::PAL_LAST_ADDR, 16'h3cff, 1'b0, 1'b1);
		pal_m[63][7:0] = 8'h3c;
		wr(image_transfer_pkg::PAL_BASE_ADDR, 16'hff69, 1'b1, 1'b0);
		pal_m[0][11:8] = 4'h9;
		for (int n = 0; n < 64; n++) begin
			pal_idx <= 6'(n);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk("palette entry", 37'(pal_m[n]), 37'(color));
		end
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			wr(image_transfer_pkg::ROM_BANK_ADDR, (seed[15:0] & 16'hc7ff) | 16'(k << 11), 1'b0, 1'b0);
			chk("bank pins", 37'(k), 37'({b_top, b_mid, b_low}));
		end
		wr(image_transfer_pkg::ROM_BANK_ADDR, 16'h0000, 1'b1, 1'b0);
		chk("bank pins lo lane", 37'h7, 37'({b_top, b_mid, b_low}));
		x0 = 2046;
		y0 = 291;
		rom0 = 32'h0101fffe;
		wr(image_transfer_pkg::START_X_ADDR, 16'hff00, 1'b0, 1'b1);
		wr(image_transfer_pkg::START_X_ADDR, 16'h00fe, 1'b1, 1'b0);
		wr(image_transfer_pkg::START_Y_ADDR, 16'hfd23, 1'b0, 1'b0);
		wr(image_transfer_pkg::ROM_UPPER_ADDR, 16'hff01, 1'b0, 1'b0);
		wr(image_transfer_pkg::ROM_LOWER_ADDR, 16'hfffe, 1'b0, 1'b0);
		wr(24'h7fffe0, 16'h0100, 1'b0, 1'b0);
		wr(image_transfer_pkg::CONTROL_ADDR, 16'h0101, 1'b1, 1'b0);
		xfer(1'b1, 3, 2, 0);
		// Long stall fills the buffer before draining
		xfer(1'b0, 40, 1, 300);
		@(posedge i_clk);
		fb_ready <= 1'b1;
		sleep <= 1'b1;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk("asleep", 37'h6, 37'({sref, black, fb_wr}));
		chk("black color", 37'h0, 37'(color));
		@(posedge i_clk);
		sleep <= 1'b0;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk("awake", 37'h0, 37'({sref, black}));
		chk("color restored", 37'(pal_m[63]), 37'(color));
		finish_test();
	end
endmodule
